// ### logic/zss_pkg.sv
// Shared constants, register map and types of the zone set selector
package zss_pkg;

  // Timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_TIME       = 1;
  localparam int unsigned MS_CYC_DEF    = CLK_HZ / 1000 * MS_TIME;
  localparam logic [6:0]  SETTLE_MAX_MS = 7'd100;

  // Sizes and variant limits
  localparam int          NIN           = 5;
  localparam int          NSET          = 10;
  localparam logic [3:0]  SA_MAX_SETS   = 4'd6;
  localparam logic [3:0]  MS_MAX_SETS   = 4'd10;
  localparam logic [4:0]  SA_IN_MASK    = 5'h07;
  localparam logic [4:0]  MS_IN_MASK    = 5'h1f;
  localparam logic [4:0]  TWO_IN_MASK   = 5'h03;
  localparam logic [4:0]  SA_ALL_HIGH   = 5'h07;

  // Register offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_DELAY     = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  OFS_CODE0     = 8'h20;

  // Field positions
  localparam int          CTRL_MASTER   = 4;
  localparam int          CTRL_CLR      = 8;
  localparam int          STAT_LOCK     = 4;
  localparam int          STAT_SEL_LSB  = 5;
  localparam int          STAT_VALID    = 10;
  localparam int          IRQ_CHG       = 0;
  localparam int          IRQ_LOCK      = 1;

  // Reset values and fixed two-set codes
  localparam logic [3:0]  SETS_RST      = 4'd2;
  localparam logic [6:0]  DELAY_RST     = 7'd0;
  localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
  localparam logic [4:0]  TWO_SET1      = 5'h01;
  localparam logic [4:0]  TWO_SET2      = 5'h02;
  // Entry i at [5*i +: 5]; bit 0 is input 1
  localparam logic [49:0] CODE_RST      = {5'h00, 5'h00, 5'h00, 5'h00, 5'h04,
                                           5'h03, 5'h05, 5'h06, 5'h01, 5'h02};

  typedef struct packed {
    logic       master;
    logic [3:0] sets;
    logic [6:0] delay_ms;
  } cfg_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef enum logic [3:0] {
    ST_START  = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_LOCK   = 4'b1000
  } state_e;

endpackage

// ### logic/zss_settle_timer.sv
// Millisecond settle timer for zone-select input changes
`timescale 1ns/10ps
module zss_settle_timer
  import zss_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC_DEF
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       restart,
  input  wire logic [6:0] delay_ms,
  // Status
  output logic            expired
);

  logic        run_q;
  logic [15:0] pre_q;
  logic [6:0]  left_q;

  // A restart in the same cycle hides expiry, so a late edge is never judged
  assign expired = run_q && (left_q == 7'd0) && !restart;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q  <= 1'b0;
      pre_q  <= 16'h0000;
      left_q <= 7'h00;
    end else if (restart) begin
      run_q  <= 1'b1;
      pre_q  <= 16'h0000;
      left_q <= delay_ms;
    end else if (expired) begin
      run_q  <= 1'b0;
    end else if (run_q) begin
      if (pre_q == 16'(MS_CYCLES - 1)) begin
        pre_q  <= 16'h0000;
        left_q <= left_q - 7'd1;
      end else begin
        pre_q  <= pre_q + 16'd1;
      end
    end
  end

endmodule

// ### logic/zone_set_selector.sv
// Zone set selector: decodes zone-select inputs into the active monitored zone set
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
module zone_set_selector
  import zss_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC_DEF
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  // Register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Zone-select inputs, bit 0 is input 1
  input  wire logic [4:0]  ZONE_SEL,
  // Monitoring status
  output logic      [3:0]  ACTIVE_SET,
  output logic             SET_VALID,
  output logic             LOCKOUT,
  output logic      [4:0]  AUX_FREE,
  // Interrupt
  output logic             IRQ
);

  bus_req_s   bus;
  cfg_s       cfg_q;
  state_e     state_q;
  logic [4:0] code_q [NSET];
  logic [4:0] set_code [NSET];
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [3:0] act_q;
  logic       valid_q;
  logic [4:0] cur_q;
  logic       first_q;
  logic [4:0] sel_q;
  logic [31:0] rdata_q;

  logic [3:0] eff_sets;
  logic [3:0] max_sets;
  logic [4:0] in_mask;
  logic [4:0] sel_now;
  logic       changed;
  logic       settled;
  logic       restart;
  logic [NSET-1:0] hit;
  logic       multi_hit;
  logic [3:0] hit_idx;
  logic [4:0] diff;
  logic       single_step;
  logic       bad_combo;
  logic       eval_fault;
  logic       ev_chg;
  logic       ev_lock;
  logic       ctrl_wr;
  logic       clr_req;
  logic [7:0] coff;
  logic       code_hit;
  logic [3:0] cidx;
  logic       wr_delay;
  logic       wr_stat;
  logic       wr_mask;
  logic       wr_code;

  assign bus = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // Configuration limits

  assign max_sets = cfg_q.master ? MS_MAX_SETS : SA_MAX_SETS;

  always_comb begin
    if (cfg_q.sets == 4'd0) begin
      eff_sets = 4'd1;
    end else if (cfg_q.sets > max_sets) begin
      eff_sets = max_sets;
    end else begin
      eff_sets = cfg_q.sets;
    end
  end

  always_comb begin
    if (eff_sets == 4'd1) begin
      in_mask = 5'h00;
    end else if (eff_sets == 4'd2) begin
      in_mask = TWO_IN_MASK;
    end else if (cfg_q.master) begin
      in_mask = MS_IN_MASK;
    end else begin
      in_mask = SA_IN_MASK;
    end
  end

  // Inputs not taken by zone selection are left for other functions; without master only inputs 1 to 3 are offered
  assign AUX_FREE = cfg_q.master ? ~in_mask : (SA_IN_MASK & ~in_mask);

  // Input sampling and change detection

  assign sel_now = ZONE_SEL & in_mask;
  assign changed = (sel_now != sel_q) && (eff_sets != 4'd1);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= 5'h00;
    end else begin
      sel_q <= sel_now;
    end
  end

  // Any further edge during the settle window restarts it, so switching
  // gear may pass through transient combinations within the delay
  assign restart = (state_q == ST_START && eff_sets != 4'd1)
                 || (changed && (state_q == ST_RUN || state_q == ST_SETTLE));

  zss_settle_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk      (CORE_CLK),
    .rst_n    (ARST_N),
    .restart  (restart),
    .delay_ms (cfg_q.delay_ms),
    .expired  (settled)
  );

  // Combination decode

  for (genvar i = 0; i < NSET; i++) begin : g_set
    assign set_code[i] = (eff_sets == 4'd2 && i < 2)
                       ? ((i == 0) ? TWO_SET1 : TWO_SET2) : code_q[i];
    assign hit[i]      = (4'(i) < eff_sets) && (sel_q == set_code[i]);

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        code_q[i] <= CODE_RST[5*i +: 5];
      end else if (wr_code && cidx == 4'(i)) begin
        code_q[i] <= bus.wdata[4:0];
      end
    end
  end

  // Two sets sharing one combination make the selection ambiguous
  assign multi_hit = (hit & (hit - 10'd1)) != 10'd0;

  always_comb begin
    hit_idx = 4'd0;
    for (int k = NSET - 1; k >= 0; k--) begin
      if (hit[k]) begin
        hit_idx = 4'(k);
      end
    end
  end

  assign bad_combo = !cfg_q.master && eff_sets >= 4'd3
                   && (sel_q == 5'h00 || sel_q == SA_ALL_HIGH);

  // Zero or one differing bit means the change was a single-input step
  assign diff        = sel_q ^ cur_q;
  assign single_step = (diff & (diff - 5'd1)) == 5'h00;

  assign eval_fault = (hit == '0) || multi_hit || bad_combo
                    || (!first_q && diff != 5'h00 && single_step);

  // Zone set state machine

  // Register write decode, one target per strobe
  always_comb begin
    ctrl_wr  = 1'b0;
    wr_delay = 1'b0;
    wr_stat  = 1'b0;
    wr_mask  = 1'b0;
    wr_code  = 1'b0;
    if (bus.wr) begin
      if (bus.addr == OFS_CTRL) begin
        ctrl_wr = 1'b1;
      end else if (bus.addr == OFS_DELAY) begin
        wr_delay = 1'b1;
      end else if (bus.addr == OFS_IRQ_STAT) begin
        wr_stat = 1'b1;
      end else if (bus.addr == OFS_IRQ_MASK) begin
        wr_mask = 1'b1;
      end else if (code_hit) begin
        wr_code = 1'b1;
      end
    end
  end

  assign clr_req = ctrl_wr && bus.wdata[CTRL_CLR];
  assign ev_lock = state_q == ST_SETTLE && settled && eval_fault;
  assign ev_chg  = (state_q == ST_SETTLE && settled && !eval_fault
                    && (act_q != hit_idx + 4'd1 || !valid_q))
                 || (state_q == ST_START && eff_sets == 4'd1 && act_q != 4'd1);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_START;
      act_q   <= 4'd0;
      valid_q <= 1'b0;
      cur_q   <= 5'h00;
      first_q <= 1'b1;
    end else begin
      case (state_q)
        ST_START: begin
          first_q <= 1'b1;
          if (eff_sets == 4'd1) begin
            act_q   <= 4'd1;
            valid_q <= 1'b1;
            state_q <= ST_RUN;
          end else begin
            state_q <= ST_SETTLE;
          end
        end
        ST_RUN: begin
          if (ctrl_wr) begin
            state_q <= ST_START;
          end else if (changed) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (ctrl_wr) begin
            state_q <= ST_START;
          end else if (settled) begin
            if (eval_fault) begin
              state_q <= ST_LOCK;
              valid_q <= 1'b0;
              act_q   <= 4'd0;
            end else begin
              act_q   <= hit_idx + 4'd1;
              valid_q <= 1'b1;
              cur_q   <= sel_q;
              first_q <= 1'b0;
              state_q <= ST_RUN;
            end
          end
        end
        ST_LOCK: begin
          // Only an explicit clear leaves lockout; reconfiguring does not
          if (clr_req) begin
            state_q <= ST_START;
          end
        end
        default: begin
          state_q <= ST_LOCK;
        end
      endcase
    end
  end

  assign ACTIVE_SET = act_q;
  assign SET_VALID  = valid_q;
  assign LOCKOUT    = state_q == ST_LOCK;

  // Registers

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_q <= '{master: 1'b0, sets: SETS_RST, delay_ms: DELAY_RST};
    end else begin
      if (ctrl_wr) begin
        cfg_q.sets   <= bus.wdata[3:0];
        cfg_q.master <= bus.wdata[CTRL_MASTER];
      end
      if (wr_delay) begin
        if (bus.wdata[31:0] > 32'(SETTLE_MAX_MS)) begin
          cfg_q.delay_ms <= SETTLE_MAX_MS;
        end else begin
          cfg_q.delay_ms <= bus.wdata[6:0];
        end
      end
    end
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q[IRQ_CHG]  <= ev_chg
        || (irq_stat_q[IRQ_CHG]
            && !(wr_stat && bus.wdata[IRQ_CHG]));
      irq_stat_q[IRQ_LOCK] <= ev_lock
        || (irq_stat_q[IRQ_LOCK]
            && !(wr_stat && bus.wdata[IRQ_LOCK]));
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_q <= bus.wdata[1:0];
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // Read decode

  assign coff     = bus.addr - OFS_CODE0;
  assign cidx     = coff[5:2];
  assign code_hit = bus.addr >= OFS_CODE0 && coff[7:2] < 6'(NSET) && coff[1:0] == 2'b00;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus.rd) begin
      if (bus.addr == OFS_CTRL) begin
        rdata_q <= {27'h0, cfg_q.master, cfg_q.sets};
      end else if (bus.addr == OFS_DELAY) begin
        rdata_q <= {25'h0, cfg_q.delay_ms};
      end else if (bus.addr == OFS_STATUS) begin
        rdata_q <= {21'h0, valid_q, sel_q, LOCKOUT, act_q};
      end else if (bus.addr == OFS_IRQ_STAT) begin
        rdata_q <= {30'h0, irq_stat_q};
      end else if (bus.addr == OFS_IRQ_MASK) begin
        rdata_q <= {30'h0, irq_mask_q};
      end else if (code_hit) begin
        rdata_q <= {27'h0, code_q[cidx]};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign REG_RDATA = rdata_q;

endmodule

// ### dv/zss_asserts.sv
// Port-level checks of the zone set selector
`timescale 1ns/10ps
module zss_asserts
  import zss_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC_DEF
) (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  // Register port
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Zone select and status
  input wire logic [4:0]  ZONE_SEL,
  input wire logic [3:0]  ACTIVE_SET,
  input wire logic        SET_VALID,
  input wire logic        LOCKOUT,
  input wire logic [4:0]  AUX_FREE,
  input wire logic        IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  logic ctl_wr;
  assign ctl_wr = REG_WR && REG_ADDR == OFS_CTRL;

  property p_lock_blank;
    LOCKOUT && $past(LOCKOUT) |-> ACTIVE_SET == 4'd0 && !SET_VALID;
  endproperty
  a_lock_blank: assert property (p_lock_blank) else $error("set shown in lockout");
  property p_lock_hold;
    LOCKOUT && !(ctl_wr && REG_WDATA[CTRL_CLR]) |=> LOCKOUT;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout left uncleared");
  property p_lock_clear;
    LOCKOUT && ctl_wr && REG_WDATA[CTRL_CLR] |=> !LOCKOUT;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lockout clear ignored");
  property p_valid_range;
    SET_VALID |-> ACTIVE_SET inside {[4'd1:4'd10]} && !LOCKOUT;
  endproperty
  a_valid_range: assert property (p_valid_range) else $error("bad valid set");
  property p_aux_sa;
    ctl_wr && !REG_WDATA[CTRL_MASTER] && REG_WDATA[3:0] inside {[4'd3:4'd6]}
      |=> AUX_FREE == 5'h00;
  endproperty
  a_aux_sa: assert property (p_aux_sa) else $error("input left free");
  property p_status;
    REG_RD && REG_ADDR == OFS_STATUS |=> REG_RDATA[3:0] == $past(ACTIVE_SET)
      && REG_RDATA[4] == $past(LOCKOUT) && REG_RDATA[10] == $past(SET_VALID);
  endproperty
  a_status: assert property (p_status) else $error("status mismatch");
  property p_unmapped;
    REG_RD && REG_ADDR == 8'h48 |=> REG_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_rd_idle;
    !$past(REG_RD) |-> REG_RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_mask_off;
    REG_WR && REG_ADDR == OFS_IRQ_MASK && REG_WDATA[1:0] == 2'b00 |=> !IRQ;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq raised");

  c_lock: cover property ($rose(LOCKOUT));
  c_ten: cover property (SET_VALID && ACTIVE_SET == 4'd10);
  c_irq: cover property ($rose(IRQ));
endmodule

bind zone_set_selector zss_asserts #(.MS_CYCLES(MS_CYCLES)) zss_asserts_i (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ZONE_SEL(ZONE_SEL),
  .ACTIVE_SET(ACTIVE_SET), .SET_VALID(SET_VALID), .LOCKOUT(LOCKOUT),
  .AUX_FREE(AUX_FREE), .IRQ(IRQ));

// ### dv/zss_switch_model.sv
// Switching equipment that drives the zone-select inputs
`timescale 1ns/10ps
module zss_switch_model (
  // Clock
  input wire logic       clk,
  // Command
  input wire logic [4:0] target,
  input wire logic       skew,
  // Zone-select drive
  output logic     [4:0] zsel
);
  logic [4:0] diff;
  assign diff = zsel ^ target;
  // Staggered mode moves one contact a cycle, as real relays do
  always @(posedge clk) begin
    if (skew) begin
      zsel <= zsel ^ (diff & (~diff + 5'h01));
    end else begin
      zsel <= target;
    end
  end
endmodule

// ### dv/zone_set_selector_tb.sv
// Self-checking bench of the zone set selector
`timescale 1ns/10ps
module zone_set_selector_tb import zss_pkg::*;;
  localparam logic [4:0] SIX [6] = '{5'h02, 5'h01, 5'h06, 5'h05, 5'h03, 5'h04};
  logic        core_clk, arst_n, reg_wr, reg_rd, set_valid, lockout, irq, skew;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0]  zone_sel, aux_free, target;
  logic [3:0]  active_set;
  int          fail_count, checked;

  zone_set_selector #(.MS_CYCLES(4)) zone_set_selector_i (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ZONE_SEL(zone_sel),
    .ACTIVE_SET(active_set), .SET_VALID(set_valid), .LOCKOUT(lockout),
    .AUX_FREE(aux_free), .IRQ(irq));
  zss_switch_model zss_switch_model_i (
    .clk(core_clk), .target(target), .skew(skew), .zsel(zone_sel));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Settles four cycles, well short of the programmed delay
  task automatic go(input logic [4:0] c, input logic s);
    @(posedge core_clk);
    target <= c;
    skew   <= s;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_set(input logic [3:0] s);
    int n = 0;
    while (active_set !== s && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(32'(active_set), 32'(s));
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (6000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    arst_n    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    target    = 5'h01;
    skew      = 1'b0;
    repeat (8) @(posedge core_clk);
    chk(32'(aux_free), 32'h04);
    arst_n <= 1'b1;
    wait_set(4'd1);
    rd(OFS_CTRL, 32'h2);
    rd(OFS_CODE0, 32'h2);
    rd(8'h48, 32'h0);
    rd(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    go(5'h02, 1'b0);
    wait_set(4'd2);
    wr(OFS_CTRL, 32'h6);
    wait_set(4'd1);
    chk(32'(aux_free), 32'h0);
    rd(OFS_STATUS, 32'h441);
    wr(OFS_DELAY, 32'h7f);
    rd(OFS_DELAY, 32'h64);
    wr(OFS_DELAY, 32'h2);
    for (int i = 1; i < 6; i++) begin
      go(SIX[i], 1'b1);
      chk(32'(active_set), 32'(i));
      wait_set(4'(i + 1));
    end
    go(5'h06, 1'b1);
    wait_set(4'd0);
    chk(32'(lockout), 32'h1);
    chk(32'(set_valid), 32'h0);
    rd(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_MASK, 32'h2);
    chk(32'(irq), 32'h1);
    // Set six owns the disallowed combination, so only the coding rule can lock
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CODE0 + 8'h14, k ? 32'h0 : 32'h7);
      go(k ? 5'h00 : 5'h07, 1'b1);
      wr(OFS_CTRL, 32'h106);
      repeat (30) @(posedge core_clk);
      #1;
      chk(32'(lockout), 32'h1);
    end
    go(5'h06, 1'b1);
    wr(OFS_CTRL, 32'h106);
    wait_set(4'd3);
    wr(OFS_IRQ_STAT, 32'h2);
    chk(32'(irq), 32'h0);
    wr(OFS_CTRL, 32'h1);
    wait_set(4'd1);
    go(5'h05, 1'b0);
    repeat (20) @(posedge core_clk);
    #1;
    chk({lockout, active_set}, 32'h01);
    wr(OFS_CODE0 + 8'h24, 32'h1e);
    rd(OFS_CODE0 + 8'h24, 32'h1e);
    go(5'h1e, 1'b0);
    wr(OFS_CTRL, 32'h1a);
    wait_set(4'd10);
    chk(32'(aux_free), 32'h0);
    go(5'h1b, 1'b0);
    wait_set(4'd0);
    chk(32'(lockout), 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    print_verdict();
  end
endmodule
